// file: rtl/fll_mon_pkg.sv
package fll_mon_pkg;
    // mode_state / mode_request encodings
    localparam logic [1:0] MODE_SCM = 2'h0;
    localparam logic [1:0] MODE_FEI = 2'h1;
    localparam logic [1:0] MODE_FBE = 2'h2;
    localparam logic [1:0] MODE_FEE = 2'h3;

    // clock_gen_output source select
    localparam logic [1:0] OUT_DCO_R = 2'h0;
    localparam logic [1:0] OUT_DCO_2R = 2'h1;
    localparam logic [1:0] OUT_EXT_R = 2'h2;
    localparam logic [1:0] OUT_NONE = 2'h3;

    localparam int CNT_W = 16;
    localparam int ERR_W = 17;
    localparam int AVG_CYCLES = 4;
    localparam int AVG_SHIFT = 2;
    localparam int DELAY_W = 4;
    localparam logic [DELAY_W-1:0] MODE_UPDATE_DELAY = 4'h4;

    // clocks as seen by the supervisor, each sampled in the system clock domain
    typedef struct packed {
        logic dco_tick;
        logic ref_tick;
        logic ref_present;
        logic dco_stable;
    } clk_obs_s;

    typedef struct packed {
        logic [1:0] mode_request;
        logic ref_select_state;
        logic clock_monitor_disable;
        logic loss_lock_reset_sel;
        logic loss_clock_reset_sel;
        logic debug_mode_enable;
        logic osc_stop_enable;
    } ctrl_s;
endpackage

// file: rtl/fll_mode_lock_monitor.sv
`timescale 1ns/1ps
//
// Function
// - entering internal engaged with error beyond unlock window: unlocked, output osc/R
// - error inside lock window for required samples: locked, output osc/R
// - when locked, filter updates once per four comparisons using four-sample average
// - enter bypass from self-clocked, from off with request 10, or on osc loss
// - bypass turns off osc and internal reference, output external reference/R
// - enter external engaged on request 11: reference good and osc stable from self-clocked, reference good from internal engaged, osc stable from bypass
// - external engaged unlocked while error outside window; loop closed
// - external engaged outputs osc/2R until first lock, then osc/R
// - count osc pulses per comparison cycle and subtract from multiply target
// - lock inside lock window, stay locked inside wider unlock window
// - unexpected exit from unlock window sets sticky loss-of-lock flag
// - flag cleared by status read then irq write, or loss-of-lock reset, or reset
// - stop entry with debug and osc-stop clear drops lock, keeps flag
// - debug cleared during stop enters off and sets loss-of-lock on wake
// - multiply, request or internal-mode trim change drops lock without flag
// - reference good when reference meets minimum frequency while monitored, or forced for 10 with ref_select_state clear
// - monitored clock below threshold sets sticky loss-of-clock flag
// - external loss of reference goes self-clocked, osc loss goes bypass
// - loss in external engaged with reference good sets state 10, bypass
// - clock loss causes lock loss; lock reset request beats clock reset request
// - reference good forcing and monitor enables follow mode table
// - after off, or bypass left on reference loss, osc not monitored until osc stable
// - mode_state follows a mode_request write only after several cycles
//
module fll_mode_lock_monitor
    import fll_mon_pkg::*;
#(
    parameter int CMP_CYCLES = 64,
    parameter int LOCK_MAX = 2,
    parameter int UNLOCK_MAX = 8,
    parameter int LOCK_SAMPLES = 4,
    parameter int REF_MIN_TICKS = 1,
    parameter int DCO_MIN_TICKS = 4,
    parameter int MON_WINDOW = 256
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire clk_obs_s CLK_OBS,
    input wire ctrl_s CTRL,
    input wire logic MODE_WRITE,
    input wire logic [CNT_W-1:0] MULTIPLY_FACTOR,
    input wire logic TRIM_CHANGE,
    input wire logic STOP_ENTER,
    input wire logic STOP_EXIT,
    input wire logic STATUS_READ,
    input wire logic IRQ_FLAG_WRITE1,
    output logic [1:0] MODE_STATE,
    output logic [1:0] MODE_REQUEST_UPD,
    output logic MODE_REQUEST_UPD_VALID,
    output logic LOCK,
    output logic LOSS_OF_LOCK_FLAG,
    output logic LOSS_OF_CLOCK_FLAG,
    output logic LOSS_LOCK_RESET_REQ,
    output logic LOSS_CLOCK_RESET_REQ,
    output logic EXT_REF_GOOD,
    output logic REF_MONITOR_EN,
    output logic DCO_MONITOR_EN,
    output logic DCO_ENABLE,
    output logic IRG_ENABLE,
    output logic [1:0] OUTPUT_SELECT,
    output logic FILTER_UPDATE,
    output logic signed [ERR_W-1:0] FILTER_ERROR,
    output logic IN_OFF
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] req;
        logic [1:0] req_pend;
        logic [DELAY_W-1:0] delay;
        logic off;
        logic off_ext_ok;
        logic wake_lol;
        logic dco_mon_hold;
        logic locked;
        logic ever_locked;
        logic [7:0] lock_cnt;
        logic [CNT_W-1:0] cmp_cnt;
        logic [CNT_W-1:0] pulse_cnt;
        logic [1:0] avg_cnt;
        logic signed [ERR_W+1:0] err_sum;
        logic [15:0] mon_cnt;
        logic [15:0] ref_cnt;
        logic [15:0] dco_cnt;
        logic ref_ok;
        logic status_seen;
        logic [CNT_W-1:0] mf_last;
        logic lol;
        logic loc;
        logic lol_rst;
        logic loc_rst;
        logic upd_valid;
        logic filt_upd;
        logic signed [ERR_W-1:0] filt_err;
    } state_s;

    state_s st_reg, st_next;

    localparam int CMP_LAST = CMP_CYCLES - 1;
    localparam int MON_LAST = MON_WINDOW - 1;

    logic signed [ERR_W-1:0] err;
    logic in_lock_win;
    logic in_unlock_win;
    logic cmp_done;
    logic mon_done;
    logic ref_mon;
    logic dco_mon;
    logic ref_good;
    logic ref_loss;
    logic dco_loss;
    logic clk_loss;
    logic expected_unlock;

    always_comb begin
        err = $signed({1'b0, MULTIPLY_FACTOR}) - $signed({1'b0, st_reg.pulse_cnt});
        in_lock_win = (err <= ERR_W'(LOCK_MAX)) && (err >= -ERR_W'(LOCK_MAX));
        in_unlock_win = (err <= ERR_W'(UNLOCK_MAX)) && (err >= -ERR_W'(UNLOCK_MAX));
        cmp_done = CLK_OBS.ref_tick && (st_reg.cmp_cnt == CNT_W'(CMP_LAST));
        mon_done = st_reg.mon_cnt == 16'(MON_LAST);
        // monitor enables per mode, request and reference select
        ref_mon = 1'b0;
        dco_mon = 1'b0;
        ref_good = 1'b0;
        if (!CTRL.clock_monitor_disable) begin
            if (st_reg.off) begin
                ref_mon = (st_reg.req == MODE_FBE) && CTRL.ref_select_state;
                ref_good = ref_mon && st_reg.ref_ok;
            end else begin
                case (st_reg.mode)
                    MODE_SCM: begin
                        dco_mon = !st_reg.dco_mon_hold;
                        if (st_reg.req == MODE_FEE ||
                            (st_reg.req == MODE_FBE && CTRL.ref_select_state)) begin
                            ref_mon = 1'b1;
                            ref_good = st_reg.ref_ok;
                        end else if (st_reg.req == MODE_FBE) begin
                            ref_good = 1'b1;
                        end
                    end
                    MODE_FEI: begin
                        dco_mon = 1'b1;
                        ref_mon = st_reg.req == MODE_FEE;
                        ref_good = ref_mon && st_reg.ref_ok;
                    end
                    MODE_FBE: begin
                        ref_mon = CTRL.ref_select_state;
                        ref_good = ref_mon ? st_reg.ref_ok : 1'b1;
                    end
                    MODE_FEE: begin
                        ref_mon = 1'b1;
                        dco_mon = 1'b1;
                        ref_good = st_reg.ref_ok;
                    end
                    default: begin
                        ref_mon = 1'b0;
                    end
                endcase
            end
        end
        ref_loss = ref_mon && mon_done && (st_reg.ref_cnt < 16'(REF_MIN_TICKS));
        dco_loss = dco_mon && mon_done && (st_reg.dco_cnt < 16'(DCO_MIN_TICKS));
        clk_loss = ref_loss || dco_loss;
        expected_unlock = (MULTIPLY_FACTOR != st_reg.mf_last) || MODE_WRITE ||
                          (TRIM_CHANGE && st_reg.mode == MODE_FEI);
    end

    always_comb begin
        st_next = st_reg;
        st_next.upd_valid = 1'b0;
        st_next.filt_upd = 1'b0;
        st_next.lol_rst = 1'b0;
        st_next.loc_rst = 1'b0;
        st_next.mf_last = MULTIPLY_FACTOR;

        // ------------------------------------------------------------
        // request capture and delayed mode update
        // ------------------------------------------------------------
        if (MODE_WRITE) begin
            st_next.req_pend = CTRL.mode_request;
            st_next.delay = MODE_UPDATE_DELAY;
        end else if (st_reg.delay != '0) begin
            st_next.delay = st_reg.delay - 1'b1;
            if (st_reg.delay == DELAY_W'(1)) begin
                st_next.req = st_reg.req_pend;
            end
        end

        // ------------------------------------------------------------
        // stop / off
        // ------------------------------------------------------------
        if (STOP_ENTER && !CTRL.osc_stop_enable && !st_reg.off) begin
            st_next.off = 1'b1;
            st_next.off_ext_ok = (st_reg.req == MODE_FBE) && ref_good;
            st_next.locked = 1'b0;
            st_next.ever_locked = 1'b0;
            st_next.wake_lol = CTRL.debug_mode_enable;
        end
        if (st_reg.off && STOP_EXIT) begin
            st_next.off = 1'b0;
            st_next.dco_mon_hold = 1'b1;
            if (st_reg.wake_lol) begin
                st_next.lol = 1'b1;
            end
            if (st_reg.req == MODE_FBE && st_reg.off_ext_ok) begin
                st_next.mode = MODE_FBE;
            end else begin
                st_next.mode = MODE_SCM;
            end
        end

        // ------------------------------------------------------------
        // mode transitions
        // ------------------------------------------------------------
        if (!st_reg.off) begin
            if (CLK_OBS.dco_stable) begin
                st_next.dco_mon_hold = 1'b0;
            end
            case (st_reg.mode)
                MODE_SCM: begin
                    if (st_reg.req == MODE_FBE && ref_good) begin
                        st_next.mode = MODE_FBE;
                    end else if (st_reg.req == MODE_FEE && ref_good && CLK_OBS.dco_stable) begin
                        st_next.mode = MODE_FEE;
                    end else if (st_reg.req == MODE_FEI && CLK_OBS.dco_stable) begin
                        st_next.mode = MODE_FEI;
                    end
                end
                MODE_FEI: begin
                    if (st_reg.req == MODE_FEE && ref_good) begin
                        st_next.mode = MODE_FEE;
                    end else if (st_reg.req != MODE_FEI) begin
                        st_next.mode = MODE_SCM;
                    end
                end
                MODE_FBE: begin
                    if (ref_loss) begin
                        st_next.mode = MODE_SCM;
                        st_next.req = MODE_SCM;
                        st_next.upd_valid = 1'b1;
                        st_next.dco_mon_hold = 1'b1;
                    end else if (st_reg.req != MODE_FBE && st_reg.req != MODE_FEE) begin
                        st_next.mode = MODE_SCM;
                    end else if (st_reg.req == MODE_FEE && CLK_OBS.dco_stable) begin
                        st_next.mode = MODE_FEE;
                    end
                end
                MODE_FEE: begin
                    if (clk_loss && ref_good && !ref_loss) begin
                        st_next.mode = MODE_FBE;
                        st_next.req = MODE_FBE;
                        st_next.upd_valid = 1'b1;
                    end else if (ref_loss) begin
                        st_next.mode = MODE_SCM;
                        st_next.req = MODE_SCM;
                        st_next.upd_valid = 1'b1;
                    end else if (st_reg.req != MODE_FEE) begin
                        st_next.mode = MODE_SCM;
                    end
                end
                default: begin
                    st_next.mode = MODE_SCM;
                end
            endcase
        end
        if (st_next.mode != st_reg.mode) begin
            st_next.locked = 1'b0;
            st_next.lock_cnt = '0;
            st_next.avg_cnt = '0;
            st_next.err_sum = '0;
            if (st_next.mode == MODE_FEE) begin
                st_next.ever_locked = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // comparison cycle, lock detector and averaging
        // ------------------------------------------------------------
        if (CLK_OBS.dco_tick) begin
            st_next.pulse_cnt = st_reg.pulse_cnt + 1'b1;
        end
        if (CLK_OBS.ref_tick) begin
            st_next.cmp_cnt = st_reg.cmp_cnt + 1'b1;
        end
        if (cmp_done) begin
            st_next.cmp_cnt = '0;
            st_next.pulse_cnt = '0;
            if (!st_reg.off && (st_reg.mode == MODE_FEI || st_reg.mode == MODE_FEE)
                && st_next.mode == st_reg.mode) begin
                if (!st_reg.locked) begin
                    if (in_lock_win) begin
                        st_next.lock_cnt = st_reg.lock_cnt + 1'b1;
                        if (st_reg.lock_cnt == 8'(LOCK_SAMPLES - 1)) begin
                            st_next.locked = 1'b1;
                            st_next.ever_locked = 1'b1;
                            st_next.lock_cnt = '0;
                        end
                    end else begin
                        st_next.lock_cnt = '0;
                    end
                    st_next.filt_upd = 1'b1; // closed loop, every comparison cycle until locked
                    st_next.filt_err = err;
                end else if (!in_unlock_win) begin
                    st_next.locked = 1'b0;
                    st_next.lol = 1'b1;
                    st_next.lol_rst = CTRL.loss_lock_reset_sel;
                end else begin
                    st_next.err_sum = st_reg.err_sum + (ERR_W+2)'(err);
                    st_next.avg_cnt = st_reg.avg_cnt + 1'b1;
                    if (st_reg.avg_cnt == 2'(AVG_CYCLES - 1)) begin
                        st_next.filt_upd = 1'b1;
                        st_next.filt_err = ERR_W'((st_reg.err_sum + (ERR_W+2)'(err))
                                                  >>> AVG_SHIFT);
                        st_next.err_sum = '0;
                    end
                end
            end
        end
        if (expected_unlock) begin
            st_next.locked = 1'b0;
            st_next.lock_cnt = '0;
        end

        // ------------------------------------------------------------
        // loss-of-clock monitor
        // ------------------------------------------------------------
        st_next.mon_cnt = st_reg.mon_cnt + 1'b1;
        if (CLK_OBS.ref_tick && CLK_OBS.ref_present) begin
            st_next.ref_cnt = st_reg.ref_cnt + 1'b1;
        end
        if (CLK_OBS.dco_tick) begin
            st_next.dco_cnt = st_reg.dco_cnt + 1'b1;
        end
        if (mon_done) begin
            st_next.mon_cnt = '0;
            st_next.ref_cnt = '0;
            st_next.dco_cnt = '0;
            st_next.ref_ok = st_reg.ref_cnt >= 16'(REF_MIN_TICKS);
        end

        // ------------------------------------------------------------
        // sticky flags; set wins over clear except the lock-detector loss-of-lock set
        // ------------------------------------------------------------
        if (STATUS_READ) begin
            st_next.status_seen = 1'b1;
        end
        if (IRQ_FLAG_WRITE1 && st_reg.status_seen) begin
            st_next.status_seen = 1'b0;
            if (!CTRL.loss_lock_reset_sel) begin
                st_next.lol = 1'b0;
            end
            if (!CTRL.loss_clock_reset_sel) begin
                st_next.loc = 1'b0;
            end
        end
        if (clk_loss) begin
            st_next.loc = 1'b1;
            st_next.loc_rst = CTRL.loss_clock_reset_sel;
            if (st_reg.mode == MODE_FEI || st_reg.mode == MODE_FEE) begin
                st_next.locked = 1'b0;
                st_next.lol = 1'b1;
                st_next.lol_rst = CTRL.loss_lock_reset_sel;
            end
        end
        // lock reset request overrides the clock reset request when both fire
        st_next.loc_rst = st_next.loc_rst && !st_next.lol_rst;
        if (st_reg.wake_lol && st_reg.off && STOP_EXIT) begin
            st_next.lol = 1'b1;
        end
        if (st_reg.off) begin
            st_next.wake_lol = st_reg.wake_lol || !CTRL.debug_mode_enable;
        end else begin
            st_next.wake_lol = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_reg <= '0; // reset clears both flags
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            EXT_REF_GOOD <= 1'b0;
            REF_MONITOR_EN <= 1'b0;
            DCO_MONITOR_EN <= 1'b0;
            DCO_ENABLE <= 1'b1;
            IRG_ENABLE <= 1'b1;
            OUTPUT_SELECT <= OUT_DCO_R;
        end else begin
            EXT_REF_GOOD <= ref_good;
            REF_MONITOR_EN <= ref_mon;
            DCO_MONITOR_EN <= dco_mon;
            // bypass turns off the oscillator and internal reference
            DCO_ENABLE <= !st_next.off && st_next.mode != MODE_FBE;
            IRG_ENABLE <= !st_next.off && st_next.mode != MODE_FBE && st_next.mode != MODE_FEE;
            if (st_next.off) begin
                OUTPUT_SELECT <= OUT_NONE;
            end else if (st_next.mode == MODE_FBE) begin
                OUTPUT_SELECT <= OUT_EXT_R;
            end else if (st_next.mode == MODE_FEE && !st_next.ever_locked) begin
                OUTPUT_SELECT <= OUT_DCO_2R;
            end else begin
                OUTPUT_SELECT <= OUT_DCO_R;
            end
        end
    end

    always_comb begin
        MODE_STATE = st_reg.mode;
        MODE_REQUEST_UPD = st_reg.req;
        MODE_REQUEST_UPD_VALID = st_reg.upd_valid;
        LOCK = st_reg.locked;
        LOSS_OF_LOCK_FLAG = st_reg.lol;
        LOSS_OF_CLOCK_FLAG = st_reg.loc;
        LOSS_LOCK_RESET_REQ = st_reg.lol_rst;
        LOSS_CLOCK_RESET_REQ = st_reg.loc_rst;
        FILTER_UPDATE = st_reg.filt_upd;
        FILTER_ERROR = st_reg.filt_err;
        IN_OFF = st_reg.off;
    end
endmodule

// file: verif/fll_mon_sva.sv
`timescale 1ns/1ps
module fll_mon_sva
    import fll_mon_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire ctrl_s CTRL,
    input wire logic MODE_WRITE,
    input wire logic IRQ_FLAG_WRITE1,
    input wire clk_obs_s CLK_OBS,
    input wire logic [1:0] MODE_STATE,
    input wire logic LOCK,
    input wire logic LOSS_OF_LOCK_FLAG,
    input wire logic LOSS_OF_CLOCK_FLAG,
    input wire logic DCO_ENABLE,
    input wire logic IRG_ENABLE,
    input wire logic [1:0] OUTPUT_SELECT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    a_bypass_clocks_off: assert property (
        MODE_STATE == MODE_FBE |-> !DCO_ENABLE && !IRG_ENABLE && OUTPUT_SELECT == OUT_EXT_R)
        else $error("bypass outputs wrong");
    a_fee_entry_half: assert property (
        MODE_STATE == MODE_FEE && $past(MODE_STATE) != MODE_FEE |-> OUTPUT_SELECT == OUT_DCO_2R)
        else $error("external entry not at half rate");
    a_fee_locked_full: assert property (
        MODE_STATE == MODE_FEE && LOCK |-> OUTPUT_SELECT == OUT_DCO_R)
        else $error("locked external output wrong");
    a_lol_flag_sticky: assert property (
        LOSS_OF_LOCK_FLAG && !IRQ_FLAG_WRITE1 |=> LOSS_OF_LOCK_FLAG)
        else $error("lock loss flag dropped");
    a_loc_flag_sticky: assert property (
        LOSS_OF_CLOCK_FLAG && !IRQ_FLAG_WRITE1 |=> LOSS_OF_CLOCK_FLAG)
        else $error("clock loss flag dropped");
    a_lol_clear_cause: assert property (
        $fell(LOSS_OF_LOCK_FLAG) |-> $past(IRQ_FLAG_WRITE1) && !$past(CTRL.loss_lock_reset_sel))
        else $error("lock loss flag cleared without ack");
    a_loc_clear_cause: assert property (
        $fell(LOSS_OF_CLOCK_FLAG) |-> $past(IRQ_FLAG_WRITE1) && !$past(CTRL.loss_clock_reset_sel))
        else $error("clock loss flag cleared without ack");
    a_mode_write_delay: assert property (
        MODE_WRITE |=> $stable(MODE_STATE) [*3])
        else $error("mode state followed request too soon");
    a_fee_entry_stable: assert property (
        $changed(MODE_STATE) && MODE_STATE == MODE_FEE |-> $past(CLK_OBS.dco_stable))
        else $error("external mode entered with unstable osc");

    c_fee_lock: cover property (MODE_STATE == MODE_FEE && $rose(LOCK));
    c_fbe_entry: cover property ($rose(MODE_STATE == MODE_FBE));
    c_lol_set: cover property ($rose(LOSS_OF_LOCK_FLAG));
endmodule

// file: verif/clk_source_model.sv
`timescale 1ns/1ps
module clk_source_model
    import fll_mon_pkg::*;
(
    input wire logic mclk,
    input wire logic [3:0] ref_div,
    input wire logic [3:0] dco_div,
    output clk_obs_s obs
);
    // a divider of zero stands for a dead source: no ticks, not present
    logic [7:0] cnt = 8'h00;
    initial obs = '0;
    always @(negedge mclk) begin
        cnt <= cnt + 8'h01;
        obs.ref_tick <= ref_div != 4'h0 && cnt % ref_div == 8'h00;
        obs.ref_present <= ref_div != 4'h0;
        obs.dco_tick <= dco_div != 4'h0 && cnt % dco_div == 8'h00;
        obs.dco_stable <= dco_div != 4'h0;
    end
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench
    import fll_mon_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    clk_obs_s obs;
    ctrl_s ctrl;
    logic mode_write, read_pulse, irq_pulse, lock, lol, loc, erg, dco_en, irg_en;
    logic [15:0] mf;
    logic [3:0] ref_div, dco_div;
    logic [1:0] mode_state, req_upd, out_sel;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    // -------------------------
    // harness
    // -------------------------
    clk_source_model i_clk_source_model (.mclk, .ref_div, .dco_div, .obs);
    fll_mode_lock_monitor #(.CMP_CYCLES(8), .MON_WINDOW(32)) i_fll_mode_lock_monitor (
        .MCLK(mclk), .RESET(reset), .CLK_OBS(obs), .CTRL(ctrl), .MODE_WRITE(mode_write),
        .MULTIPLY_FACTOR(mf), .TRIM_CHANGE(1'b0), .STOP_ENTER(1'b0), .STOP_EXIT(1'b0),
        .STATUS_READ(read_pulse), .IRQ_FLAG_WRITE1(irq_pulse), .MODE_STATE(mode_state),
        .MODE_REQUEST_UPD(req_upd), .MODE_REQUEST_UPD_VALID(), .LOCK(lock),
        .LOSS_OF_LOCK_FLAG(lol), .LOSS_OF_CLOCK_FLAG(loc), .LOSS_LOCK_RESET_REQ(),
        .LOSS_CLOCK_RESET_REQ(), .EXT_REF_GOOD(erg), .REF_MONITOR_EN(), .DCO_MONITOR_EN(),
        .DCO_ENABLE(dco_en), .IRG_ENABLE(irg_en), .OUTPUT_SELECT(out_sel), .FILTER_UPDATE(),
        .FILTER_ERROR(), .IN_OFF());

    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [1:0] seen, input logic [1:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // 0 mode, 1 lock, 2 clock loss flag, 3 lock loss flag; a miss shows in the next chk
    task automatic wait_on(input int w, input logic [1:0] v, input int lim);
        logic [1:0] s;
        repeat (lim) begin
            @(negedge mclk);
            s = w == 0 ? mode_state : w == 1 ? 2'(lock) : w == 2 ? 2'(loc) : 2'(lol);
            if (s === v) begin
                return;
            end
        end
    endtask

    task automatic pulse(input int w);
        @(negedge mclk);
        mode_write = w == 0;
        read_pulse = w == 1;
        irq_pulse = w == 2;
        @(negedge mclk);
        {mode_write, read_pulse, irq_pulse} = 3'h0;
    endtask

    // -------------------------
    // scenarios
    // -------------------------
    task automatic t_reset();
        chk("lol", 2'(lol), 2'h0);
        chk("loc", 2'(loc), 2'h0);
        $display("t_reset done");
    endtask

    task automatic t_fee();
        ctrl.mode_request = MODE_FEE;
        pulse(0);
        chk("early", mode_state, MODE_SCM);
        wait_on(0, MODE_FEE, 300);
        chk("fee", mode_state, MODE_FEE);
        chk("sel2r", out_sel, OUT_DCO_2R);
        wait_on(1, 2'h1, 2000);
        chk("lock", 2'(lock), 2'h1);
        chk("selr", out_sel, OUT_DCO_R);
        chk("erg", 2'(erg), 2'h1);
        $display("t_fee done");
    endtask

    // target moves by one count: lock must drop without flag, then return
    task automatic t_mfd();
        mf = 16'h0021;
        wait_on(1, 2'h0, 8);
        chk("drop", 2'(lock), 2'h0);
        chk("lolq", 2'(lol), 2'h0);
        wait_on(1, 2'h1, 2000);
        chk("relock", 2'(lock), 2'h1);
        $display("t_mfd done");
    endtask

    task automatic t_unlock();
        dco_div = 4'h3;
        wait_on(3, 2'h1, 1000);
        chk("lolset", 2'(lol), 2'h1);
        chk("unl", 2'(lock), 2'h0);
        chk("selu", out_sel, OUT_DCO_R);
        pulse(2);
        chk("keep", 2'(lol), 2'h1);
        pulse(1);
        pulse(2);
        @(negedge mclk);
        chk("clr", 2'(lol), 2'h0);
        dco_div = 4'h2;
        wait_on(1, 2'h1, 2000);
        chk("lock2", 2'(lock), 2'h1);
        $display("t_unlock done");
    endtask

    task automatic t_dco_loss();
        dco_div = 4'h0;
        wait_on(2, 2'h1, 300);
        chk("locset", 2'(loc), 2'h1);
        wait_on(0, MODE_FBE, 20);
        chk("fbe", mode_state, MODE_FBE);
        chk("req", req_upd, MODE_FBE);
        chk("nolock", 2'(lock), 2'h0);
        chk("osc", {dco_en, irg_en}, 2'h0);
        chk("selx", out_sel, OUT_EXT_R);
        pulse(1);
        pulse(2);
        @(negedge mclk);
        chk("locclr", 2'(loc), 2'h0);
        $display("t_dco_loss done");
    endtask

    task automatic t_ref_loss();
        ref_div = 4'h0;
        wait_on(0, MODE_SCM, 300);
        chk("scm", mode_state, MODE_SCM);
        chk("loc2", 2'(loc), 2'h1);
        // reference good is registered one cycle behind the mode change
        @(negedge mclk);
        chk("erg0", 2'(erg), 2'h0);
        $display("t_ref_loss done");
    endtask

    initial begin
        ctrl = '0;
        ctrl.ref_select_state = 1'b1;
        {mode_write, read_pulse, irq_pulse} = 3'h0;
        mf = 16'h0020;
        ref_div = 4'h8;
        dco_div = 4'h2;
        repeat (6) @(negedge mclk);
        reset = 1'b0;
        t_reset();
        t_fee();
        t_mfd();
        t_unlock();
        t_dco_loss();
        t_ref_loss();
        end_of_test();
    end
endmodule

bind fll_mode_lock_monitor fll_mon_sva i_fll_mon_sva (
    .MCLK, .RESET, .CTRL, .MODE_WRITE, .IRQ_FLAG_WRITE1, .CLK_OBS, .MODE_STATE, .LOCK,
    .LOSS_OF_LOCK_FLAG, .LOSS_OF_CLOCK_FLAG, .DCO_ENABLE, .IRG_ENABLE, .OUTPUT_SELECT);
